// ---- core/uub_pkg.sv ----
// Constants, register map and carrier types of the USB to serial bridge core.
// Assumes one 20 MHz clock; the USB serial interface engine sits outside this core.

package uub_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int unsigned CLK_HZ            = 20_000_000;
   localparam int unsigned SUSPEND_IDLE_US   = 3000;
   localparam int unsigned SUSPEND_CYCLES    = (CLK_HZ / 1_000_000) * SUSPEND_IDLE_US + 1;
   localparam int unsigned POR_DELAY_MS      = 50;
   localparam int unsigned POR_CYCLES        = (CLK_HZ / 1000) * POR_DELAY_MS;
   localparam int unsigned WAKE_STARTUP_CLKS = 16;
   localparam int unsigned DEFAULT_BAUD      = 9600;
   localparam int unsigned MAX_BAUD          = 3_400_000;
   localparam logic [15:0] BAUD_DIV_RESET    = 16'((CLK_HZ + DEFAULT_BAUD / 2) / DEFAULT_BAUD);
   localparam logic [15:0] BAUD_DIV_MIN      = 16'(CLK_HZ / MAX_BAUD);
   localparam int unsigned FIFO_DEPTH        = 128;
   localparam int unsigned RTS_MARGIN        = 4;

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_BAUD   = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_LEVEL  = 8'h0c;

   localparam int unsigned CTRL_FLOW_BIT     = 0;
   localparam int unsigned CTRL_WAKE_EN_BIT  = 1;
   localparam int unsigned CTRL_PARITY_LSB   = 2;
   localparam int unsigned CTRL_TWO_STOP_BIT = 4;
   localparam int unsigned CTRL_WAKE_REQ_BIT = 8;
   localparam int unsigned ST_SUSPENDED_BIT  = 8;
   localparam int unsigned ST_WAKING_BIT     = 9;
   localparam int unsigned ST_TX_BUSY_BIT    = 10;
   localparam int unsigned ST_RX_BUSY_BIT    = 11;
   localparam int unsigned LEVEL_RX_LSB      = 16;

   localparam logic [1:0] EP_CONTROL   = 2'h0;
   localparam logic [1:0] EP_INTERRUPT = 2'h1;
   localparam logic [1:0] EP_BULK_OUT  = 2'h2;
   localparam logic [1:0] EP_BULK_IN   = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_EVEN = 2'b01,
      PAR_ODD  = 2'b10
   } uub_parity_type;

   typedef struct packed {
      logic           twoStop;
      uub_parity_type parity;
      logic           wakeEn;
      logic           flowEn;
   } uub_cfg_type;

   typedef struct packed {
      logic parityErr;
      logic framingErr;
      logic overrun;
      logic txDone;
      logic rxDone;
   } uub_event_type;

   localparam uub_cfg_type CFG_RESET = '{twoStop: 1'b0, parity: PAR_NONE, wakeEn: 1'b0, flowEn: 1'b0};

endpackage : uub_pkg

// ---- core/uub_fifo.sv ----
// Byte FIFO with valid/ready on both sides and a fill count.
// Assumes the same clock and synchronous reset as its parent.
`timescale 1ns/1ps
`default_nettype none

module uub_fifo
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 128
)
(
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic                           inValid,
   input  wire logic [WIDTH-1:0]               inData,
   output logic                                inReady,
   output logic                                outValid,
   output logic [WIDTH-1:0]                    outData,
   input  wire logic                           outReady,
   output logic [$clog2(DEPTH+1)-1:0]          count
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad_depth
      $error("uub_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    rdPtr_q;
   logic [CW-1:0]    count_q;
   logic             push;
   logic             pop;

   assign inReady  = count_q != CW'(DEPTH);
   assign outValid = count_q != '0;
   assign outData  = mem_q[rdPtr_q];
   assign count    = count_q;
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wrPtr_q] <= inData;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wrPtr_q <= wrPtr_q + 1'b1;
         if (pop)
            rdPtr_q <= rdPtr_q + 1'b1;
         if (push != pop)
            count_q <= push ? count_q + 1'b1 : count_q - 1'b1;
      end
   end

endmodule : uub_fifo

`default_nettype wire

// ---- core/uub_core.sv ----
// USB to serial bridge core: endpoint byte ports, suspend/wake, UART, APB registers.
// Assumes an external USB engine delivering decoded bytes and bus activity on clk.
`timescale 1ns/1ps
`default_nettype none

module uub_core
#(
   parameter int unsigned POR_WAIT     = uub_pkg::POR_CYCLES,
   parameter int unsigned SUSPEND_WAIT = uub_pkg::SUSPEND_CYCLES,
   parameter int unsigned DEPTH        = uub_pkg::FIFO_DEPTH
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic [1:0]  usbEp,
   input  wire logic        usbOutValid,
   input  wire logic [7:0]  usbOutData,
   output logic             usbOutReady,
   output logic             usbInValid,
   output logic [7:0]       usbInData,
   input  wire logic        usbInReady,
   output logic [1:0]       usbInEp,
   input  wire logic        usbActivity,
   input  wire logic        usbResume,
   output logic             remoteWake,
   output logic             suspended,
   output logic             uartTx,
   input  wire logic        uartRx,
   input  wire logic        ctsN,
   output logic             rtsN,
   output logic             ledN
);
   import uub_pkg::*;

   localparam int unsigned CW = $clog2(DEPTH + 1);

   if (POR_WAIT < 1 || SUSPEND_WAIT < 2 || DEPTH <= RTS_MARGIN || CW > 8)
   begin : g_bad_param
      $error("uub_core: unsupported parameter values");
   end

   typedef enum logic [1:0] {
      PWR_ACTIVE  = 2'b00,
      PWR_SUSPEND = 2'b01,
      PWR_WAKE    = 2'b10
   } uub_pwr_type;

   typedef enum logic [2:0] {
      SER_IDLE  = 3'b000,
      SER_START = 3'b001,
      SER_DATA  = 3'b010,
      SER_PAR   = 3'b011,
      SER_STOP1 = 3'b100,
      SER_STOP2 = 3'b101
   } uub_ser_type;

   ////////////////////////////////////////////////////////////////////////////
   // Power-on delay: all but the counter, the pin synchronisers and the APB hit/read-data registers is held in reset
   logic [31:0]   porCnt_q;
   logic          porBusy_q;
   logic          sysRst;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         porCnt_q  <= '0;
         porBusy_q <= 1'b1;
      end
      else if (porBusy_q)
      begin
         porCnt_q  <= porCnt_q + 32'h1;
         porBusy_q <= porCnt_q != POR_WAIT - 1;
      end
   end

   assign sysRst = rst | porBusy_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the second stage is looked at, and the third rx stage too for start-edge detection
   logic [2:0]    rxSync_q;
   logic [1:0]    ctsSync_q;
   logic          rxIn;
   logic          rxFall;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rxSync_q  <= 3'h7;
         ctsSync_q <= 2'h3;
      end
      else
      begin
         rxSync_q  <= {rxSync_q[1:0], uartRx};
         ctsSync_q <= {ctsSync_q[0], ctsN};
      end
   end

   assign rxIn   = rxSync_q[1];
   assign rxFall = rxSync_q[2] & ~rxSync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // Registers and FIFOs
   uub_cfg_type   cfg_q;
   logic [15:0]   baudDiv_q;
   uub_event_type events_q;
   uub_event_type evSet;
   logic          wakeReq;
   uub_pwr_type   pwr_q;
   uub_ser_type   txState_q;
   uub_ser_type   rxState_q;
   logic          txFifoInValid;
   logic          txFifoInReady;
   logic          txFifoOutValid;
   logic [7:0]    txFifoOutData;
   logic          txPop;
   logic [CW-1:0] txCount;
   logic          rxPush;
   logic [7:0]    rxShift_q;
   logic          rxFifoInReady;
   logic [CW-1:0] rxCount;
   logic          active;

   // Bulk OUT and IN byte ports stay closed until the power-on delay has run out
   assign active = (pwr_q == PWR_ACTIVE) & ~sysRst;

   // Bulk OUT feeds the transmitter; control and interrupt OUT bytes are sunk
   assign txFifoInValid = usbOutValid & (usbEp == EP_BULK_OUT) & active;
   assign usbOutReady   = (usbEp == EP_BULK_OUT) ? txFifoInReady & active : 1'b1;
   assign usbInEp       = EP_BULK_IN;

   uub_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
      .clk      (clk),
      .rst      (sysRst),
      .inValid  (txFifoInValid),
      .inData   (usbOutData),
      .inReady  (txFifoInReady),
      .outValid (txFifoOutValid),
      .outData  (txFifoOutData),
      .outReady (txPop),
      .count    (txCount)
   );

   logic          rxFifoOutValid;

   uub_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
      .clk      (clk),
      .rst      (sysRst),
      .inValid  (rxPush),
      .inData   (rxShift_q),
      .inReady  (rxFifoInReady),
      .outValid (rxFifoOutValid),
      .outData  (usbInData),
      .outReady (usbInReady & active),
      .count    (rxCount)
   );

   assign usbInValid = rxFifoOutValid & active;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, read data captured in the setup cycle
   logic          setup;
   logic          hit_q;
   logic          hitNow;
   logic          wrEn;
   logic [31:0]   rdData;
   logic [31:0]   prdata_q;

   assign setup  = psel & ~penable;
   assign hitNow = paddr == ADDR_CTRL || paddr == ADDR_BAUD || paddr == ADDR_STATUS || paddr == ADDR_LEVEL;
   assign pready  = penable;
   assign pslverr = penable & ~hit_q;
   assign prdata  = prdata_q;
   assign wrEn    = psel & penable & pwrite & hit_q;
   assign wakeReq = wrEn & paddr == ADDR_CTRL & pwdata[CTRL_WAKE_REQ_BIT];

   always_comb
   begin
      rdData = '0;
      case (paddr)
         ADDR_CTRL:   rdData[4:0] = cfg_q;
         ADDR_BAUD:   rdData[15:0] = baudDiv_q;
         ADDR_STATUS:
         begin
            rdData[4:0]              = events_q;
            rdData[ST_SUSPENDED_BIT] = pwr_q == PWR_SUSPEND;
            rdData[ST_WAKING_BIT]    = pwr_q == PWR_WAKE;
            rdData[ST_TX_BUSY_BIT]   = txState_q != SER_IDLE;
            rdData[ST_RX_BUSY_BIT]   = rxState_q != SER_IDLE;
         end
         ADDR_LEVEL:
         begin
            rdData[7:0]                = 8'(txCount);
            rdData[LEVEL_RX_LSB +: 8] = 8'(rxCount);
         end
         default:     rdData = '0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hit_q    <= 1'b0;
         prdata_q <= '0;
      end
      else if (setup)
      begin
         hit_q    <= hitNow;
         prdata_q <= pwrite ? 32'h0 : rdData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sysRst)
      begin
         cfg_q     <= CFG_RESET;
         baudDiv_q <= BAUD_DIV_RESET;
      end
      else if (wrEn && paddr == ADDR_CTRL)
      begin
         cfg_q.flowEn  <= pwdata[CTRL_FLOW_BIT];
         cfg_q.wakeEn  <= pwdata[CTRL_WAKE_EN_BIT];
         cfg_q.parity  <= (pwdata[CTRL_PARITY_LSB +: 2] == 2'b11) ? PAR_NONE
                          : uub_parity_type'(pwdata[CTRL_PARITY_LSB +: 2]);
         cfg_q.twoStop <= pwdata[CTRL_TWO_STOP_BIT];
      end
      else if (wrEn && paddr == ADDR_BAUD)
      begin
         // Clamped to BAUD_DIV_MIN (5 clocks per bit), so 4 MBd, above MAX_BAUD, is the limit
         baudDiv_q <= (pwdata[15:0] < BAUD_DIV_MIN) ? BAUD_DIV_MIN : pwdata[15:0];
      end
   end

   // Sticky events, write one to clear; a new event beats its own clear
   always_ff @(posedge clk)
   begin
      if (sysRst)
         events_q <= '0;
      else if (wrEn && paddr == ADDR_STATUS)
         events_q <= (events_q & ~pwdata[4:0]) | evSet;
      else
         events_q <= events_q | evSet;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Suspend, resume and wake
   logic [31:0]   idleCnt_q;
   logic [4:0]    wakeCnt_q;
   logic          remoteWake_q;

   always_ff @(posedge clk)
   begin
      if (sysRst)
      begin
         pwr_q        <= PWR_ACTIVE;
         idleCnt_q    <= '0;
         wakeCnt_q    <= '0;
         remoteWake_q <= 1'b0;
      end
      else
      begin
         remoteWake_q <= 1'b0;
         case (pwr_q)
            PWR_ACTIVE:
            begin
               idleCnt_q <= usbActivity ? 32'h0 : idleCnt_q + 32'h1;
               if (!usbActivity && idleCnt_q == SUSPEND_WAIT - 1)
                  pwr_q <= PWR_SUSPEND;
            end
            PWR_SUSPEND:
            begin
               idleCnt_q <= '0;
               if (usbResume)
                  pwr_q <= PWR_ACTIVE;
               else if (rxFall)
               begin
                  pwr_q        <= PWR_WAKE;
                  wakeCnt_q    <= '0;
                  remoteWake_q <= cfg_q.wakeEn;
               end
               else if (wakeReq)
                  remoteWake_q <= cfg_q.wakeEn;
            end
            PWR_WAKE:
            begin
               wakeCnt_q <= wakeCnt_q + 5'h1;
               if (wakeCnt_q == 5'(WAKE_STARTUP_CLKS - 1))
                  pwr_q <= PWR_ACTIVE;
            end
            default: pwr_q <= PWR_ACTIVE;
         endcase
      end
   end

   assign remoteWake = remoteWake_q;
   assign suspended  = pwr_q != PWR_ACTIVE;

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter; CTS is honoured only between characters
   logic [15:0]   txCnt_q;
   logic [7:0]    txShift_q;
   logic [2:0]    txBit_q;
   logic          txPar_q;
   logic          txLine_q;
   logic          txDone;
   logic          txTick;

   assign txTick = txCnt_q == 16'h0;
   assign txPop  = txState_q == SER_IDLE & txFifoOutValid & active
                   & (~cfg_q.flowEn | ~ctsSync_q[1]);

   always_ff @(posedge clk)
   begin
      if (sysRst)
      begin
         txState_q <= SER_IDLE;
         txCnt_q   <= '0;
         txShift_q <= '0;
         txBit_q   <= '0;
         txPar_q   <= 1'b0;
         txLine_q  <= 1'b1;
      end
      else if (txState_q == SER_IDLE)
      begin
         if (txPop)
         begin
            txShift_q <= txFifoOutData;
            txPar_q   <= ^txFifoOutData ^ (cfg_q.parity == PAR_ODD);
            txCnt_q   <= baudDiv_q - 16'h1;
            txBit_q   <= '0;
            txLine_q  <= 1'b0;
            txState_q <= SER_START;
         end
      end
      else if (!txTick)
         txCnt_q <= txCnt_q - 16'h1;
      else
      begin
         txCnt_q <= baudDiv_q - 16'h1;
         case (txState_q)
            SER_START:
            begin
               txLine_q  <= txShift_q[0];
               txState_q <= SER_DATA;
            end
            SER_DATA:
            begin
               txShift_q <= txShift_q >> 1;
               txBit_q   <= txBit_q + 3'h1;
               if (txBit_q != 3'h7)
                  txLine_q <= txShift_q[1];
               else if (cfg_q.parity != PAR_NONE)
               begin
                  txLine_q  <= txPar_q;
                  txState_q <= SER_PAR;
               end
               else
               begin
                  txLine_q  <= 1'b1;
                  txState_q <= SER_STOP1;
               end
            end
            SER_PAR:
            begin
               txLine_q  <= 1'b1;
               txState_q <= SER_STOP1;
            end
            SER_STOP1: txState_q <= cfg_q.twoStop ? SER_STOP2 : SER_IDLE;
            default:   txState_q <= SER_IDLE;
         endcase
      end
   end

   assign txDone = txTick & (txState_q == SER_STOP2 | (txState_q == SER_STOP1 & ~cfg_q.twoStop));
   assign uartTx = txLine_q;

   ////////////////////////////////////////////////////////////////////////////
   // Receiver; second stop bit is not checked, next start may follow it
   logic [15:0]   rxCnt_q;
   logic [2:0]    rxBit_q;
   logic          rxParErr_q;
   logic          rxTick;
   logic          rxStop;

   assign rxTick = rxCnt_q == 16'h0;
   assign rxStop = rxTick & rxState_q == SER_STOP1;
   assign rxPush = rxStop;

   always_ff @(posedge clk)
   begin
      if (sysRst)
      begin
         rxState_q  <= SER_IDLE;
         rxCnt_q    <= '0;
         rxShift_q  <= '0;
         rxBit_q    <= '0;
         rxParErr_q <= 1'b0;
      end
      else if (rxState_q == SER_IDLE)
      begin
         if (rxFall && active)
         begin
            rxCnt_q    <= baudDiv_q >> 1; // Sample mid-bit
            rxParErr_q <= 1'b0;
            rxState_q  <= SER_START;
         end
      end
      else if (!rxTick)
         rxCnt_q <= rxCnt_q - 16'h1;
      else
      begin
         rxCnt_q <= baudDiv_q - 16'h1;
         case (rxState_q)
            SER_START:
            begin
               rxBit_q   <= '0;
               rxState_q <= rxIn ? SER_IDLE : SER_DATA;
            end
            SER_DATA:
            begin
               rxShift_q <= {rxIn, rxShift_q[7:1]};
               rxBit_q   <= rxBit_q + 3'h1;
               if (rxBit_q == 3'h7)
                  rxState_q <= (cfg_q.parity != PAR_NONE) ? SER_PAR : SER_STOP1;
            end
            SER_PAR:
            begin
               rxParErr_q <= rxIn ^ ^rxShift_q ^ (cfg_q.parity == PAR_ODD);
               rxState_q  <= SER_STOP1;
            end
            default:   rxState_q <= SER_IDLE;
         endcase
      end
   end

   always_comb
   begin
      evSet            = '0;
      evSet.rxDone     = rxStop;
      evSet.txDone     = txDone;
      evSet.overrun    = rxStop & ~rxFifoInReady;
      evSet.framingErr = rxStop & ~rxIn;
      evSet.parityErr  = rxStop & rxParErr_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flow control and activity outputs
   logic          rtsN_q;
   logic          ledN_q;

   always_ff @(posedge clk)
   begin
      if (sysRst)
      begin
         rtsN_q <= 1'b1;
         ledN_q <= 1'b1;
      end
      else
      begin
         rtsN_q <= cfg_q.flowEn & (32'(rxCount) >= DEPTH - RTS_MARGIN);
         ledN_q <= txState_q == SER_IDLE & rxState_q == SER_IDLE;
      end
   end

   assign rtsN = rtsN_q;
   assign ledN = ledN_q;

endmodule : uub_core

`default_nettype wire

// ---- bench/uub_serial_model.sv ----
// Serial device model on the core's UART pins.
// Assumes BIT core clocks per bit.
`timescale 1ns/1ps
`default_nettype none
module uub_serial_model
#(parameter int BIT = 8)
(
   input  wire logic clk,
   input  wire logic txLine,
   output var  logic rxLine = 1'b1,
   output var  logic ctsN = 1'b0
);
   task automatic bitAt(output logic b);
      repeat (BIT) @(posedge clk);
      b = txLine;
   endtask : bitAt
   task automatic send(input logic [7:0] d, input logic par, input logic usePar, input logic stp);
      logic [11:0] f;
      f = {1'b1, stp, par, d, 1'b0};
      for (int i = 0; i < 12; i++)
         if (i != 9 || usePar)
         begin
            @(posedge clk) rxLine <= f[i];
            repeat (BIT - 1) @(posedge clk);
         end
   endtask : send
   task automatic recv(output logic [7:0] d, output logic par, input logic usePar, output logic ok);
      int   n;
      logic s;
      par = 1'b0;
      for (n = 0; txLine && n < 9000; n++) @(posedge clk);
      repeat (BIT / 2) @(posedge clk);
      ok = !txLine && n < 9000;
      for (int i = 0; i < 8; i++) bitAt(d[i]);
      if (usePar) bitAt(par);
      bitAt(s);
      ok = ok && s;
   endtask : recv
endmodule : uub_serial_model
`default_nettype wire

// ---- bench/uub_core_monitor.sv ----
// Checker on the bridge core's ports.
// Assumes a power-on wait of at least 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module uub_core_monitor
(
   input wire logic clk,
   input wire logic rst,
   input wire logic usbActivity,
   input wire logic usbResume,
   input wire logic uartRx,
   input wire logic uartTx,
   input wire logic rtsN,
   input wire logic remoteWake,
   input wire logic suspended,
   input wire logic usbInValid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_tx_idle:
      assert property ($fell(rst) |-> uartTx [*8]) else $error("tx not idle");
   a_rts_idle:
      assert property ($fell(rst) |-> rtsN [*8]) else $error("rts low in reset");
   a_wake_pulse:
      assert property (remoteWake |=> !remoteWake) else $error("wake pulse long");
   a_wake_cause:
      assert property ($rose(remoteWake) |-> $past(suspended)) else $error("wake while active");
   a_resume_wakes:
      assert property (suspended && usbResume |=> !suspended) else $error("resume ignored");
   a_rx_wake_hold:
      assert property (suspended && $fell(uartRx) && !usbResume |=> suspended [*8] ##1 suspended [*8])
         else $error("start-up short");
   a_busy_awake:
      assert property (usbActivity && !suspended |=> !suspended) else $error("suspend on activity");
   a_in_masked:
      assert property (suspended |-> !usbInValid) else $error("IN valid in suspend");
endmodule : uub_core_monitor
bind uub_core uub_core_monitor mon (.clk, .rst, .usbActivity, .usbResume, .uartRx, .uartTx, .rtsN,
   .remoteWake, .suspended, .usbInValid);
`default_nettype wire

// ---- bench/usb_uart_bridge_core_tb.sv ----
// Bench for the bridge core: APB, USB byte ports, UART frames, suspend.
// Assumes the serial model on the UART pins and shortened counts.
`timescale 1ns/1ps
`default_nettype none
module usb_uart_bridge_core_tb;
   import uub_pkg::*;
   localparam int BIT = 8;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, usbOutValid = 1'b0;
   logic        usbInReady = 1'b0, usbActivity = 1'b1, usbResume = 1'b0, err, ok, par;
   logic [1:0]  usbEp = 2'h0, usbInEp;
   logic [7:0]  paddr = 8'h00, usbOutData = 8'h00, usbInData, got;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, usbOutReady, usbInValid, remoteWake, suspended, uartTx, uartRx, ctsN, rtsN, ledN;
   int          error_cnt = 0, check_count = 0;
   uub_core #(.POR_WAIT(20), .SUSPEND_WAIT(50), .DEPTH(8)) dut (.clk, .rst, .paddr, .psel, .penable, .pwrite,
      .pwdata, .pready, .prdata, .pslverr, .usbEp, .usbOutValid, .usbOutData, .usbOutReady, .usbInValid,
      .usbInData, .usbInReady, .usbInEp, .usbActivity, .usbResume, .remoteWake, .suspended, .uartTx,
      .uartRx, .ctsN, .rtsN, .ledN);
   uub_serial_model #(.BIT(BIT)) dev (.clk, .txLine(uartTx), .rxLine(uartRx), .ctsN);
   initial
   begin
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // Bounded wait; a timeout ends the run
   task automatic waitFor(ref logic s);
      int n;
      for (n = 0; s !== 1'b1 && n < 3000; n++) @(negedge clk);
      check(n < 3000, 1'b1);
      if (n == 3000) end_sim();
   endtask : waitFor
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (n = 0; pready !== 1'b1 && n < 16; n++) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(n < 16, 1'b1);
      if (n == 16) end_sim();
   endtask : apb
   task automatic usbOut(input logic [7:0] d);
      int n;
      @(posedge clk);
      usbEp <= EP_BULK_OUT;
      usbOutValid <= 1'b1;
      usbOutData <= d;
      // Ready only moves on rising edges, so the falling edge shows what the next edge takes
      @(negedge clk);
      for (n = 0; usbOutReady !== 1'b1 && n < 99; n++) @(negedge clk);
      check(n < 99, 1'b1);
      if (n == 99) end_sim();
      @(posedge clk);
      usbOutValid <= 1'b0;
   endtask : usbOut
   task automatic popIn(input logic [7:0] d);
      waitFor(usbInValid);
      check(usbInData, d);
      @(posedge clk) usbInReady <= 1'b1;
      @(posedge clk) usbInReady <= 1'b0;
   endtask : popIn
   function automatic logic parOf(input logic [7:0] d, input int p);
      return (p == 2) ? ~^d : ^d;
   endfunction : parOf
   task automatic t_regs;
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, ADDR_BAUD, 32'h0);
      check(rd, {16'h0, BAUD_DIV_RESET});
      apb(1'b1, ADDR_BAUD, 32'(BIT));
      apb(1'b0, ADDR_BAUD, 32'h0);
      check(rd, 32'(BIT));
      apb(1'b0, 8'h10, 32'h0);
      check(err, 1'b1);
      check(usbInEp, EP_BULK_IN);
      check(rtsN, 1'b0);
      $display("regs done");
   endtask : t_regs
   task automatic t_frames;
      logic [7:0] d;
      logic       pe;
      for (int p = 0; p < 3; p++)
      begin
         d = 8'ha5 ^ 8'(p * 19);
         pe = (p != 0);
         apb(1'b1, ADDR_CTRL, 32'(p * 4 + (p % 2) * 16));
         fork
            usbOut(d);
            dev.recv(got, par, pe, ok);
         join
         @(negedge clk) check(ledN, 1'b0);
         check(ok, 1'b1);
         if (!ok) end_sim();
         check(got, d);
         if (pe) check(par, parOf(d, p));
         dev.send(~d, parOf(~d, p), pe, 1'b1);
         popIn(~d);
         apb(1'b0, ADDR_STATUS, 32'h0);
         check(rd[1:0], 2'b11);
         check(ledN, 1'b1);
         apb(1'b1, ADDR_STATUS, 32'h1f);
         dev.send(d, ~parOf(d, p), pe, pe);
         popIn(d);
         apb(1'b0, ADDR_STATUS, 32'h0);
         check(rd[4:3], pe ? 2'b10 : 2'b01);
         apb(1'b1, ADDR_STATUS, 32'h1f);
      end
      $display("frames done");
   endtask : t_frames
   task automatic t_suspend;
      @(posedge clk) usbActivity <= 1'b0;
      waitFor(suspended);
      @(posedge clk) usbResume <= 1'b1;
      @(posedge clk) usbResume <= 1'b0;
      @(negedge clk) check(suspended, 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h2);
      waitFor(suspended);
      // Bus activity must return within SUSPEND_WAIT cycles after start-up, or the idle timer suspends the core again
      fork
         dev.send(8'hf0, 1'b0, 1'b0, 1'b1);
         begin
            waitFor(remoteWake);
            check(suspended, 1'b1);
            @(posedge clk) usbActivity <= 1'b1;
         end
      join
      @(negedge clk) check(suspended, 1'b0);
      $display("suspend done");
   endtask : t_suspend
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (22) @(posedge clk);
      t_regs();
      t_frames();
      t_suspend();
      end_sim();
   end
endmodule : usb_uart_bridge_core_tb
`default_nettype wire
